// ### verilog/sea_pkg.sv
// shared constants and types for the serial spd eeprom slave
package sea_pkg;
    // device type codes in the top nibble of the select byte
    localparam logic [3:0] MEM_TYPE = 4'hA;
    localparam logic [3:0] CMD_TYPE = 4'h6;
    // command codes carried in select bits 3..1
    localparam logic [2:0] SEL_B0    = 3'h1;
    localparam logic [2:0] SEL_B1    = 3'h4;
    localparam logic [2:0] SEL_B2    = 3'h5;
    localparam logic [2:0] SEL_B3    = 3'h0;
    localparam logic [2:0] SEL_CLR   = 3'h3;
    localparam logic [2:0] SEL_PAGE0 = 3'h6;
    localparam logic [2:0] SEL_PAGE1 = 3'h7;
    // array geometry and delivery state
    localparam int         PAGE_BYTES = 16;
    localparam logic [4:0] PAGE_MAX   = 5'h10;
    localparam logic [7:0] ERASED     = 8'hFF;
    // internal_write_time, in microseconds, and its cycle count
    localparam int          WRITE_TIME_US = 5;
    localparam int          CLK_MHZ       = 100;
    localparam logic [19:0] WRITE_CYCLES  = 20'(WRITE_TIME_US * CLK_MHZ);
    // register byte offsets and reset values
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic       CTRL_RST  = 1'b1;

    // serial protocol position
    typedef enum logic [3:0] {
        P_IDLE, P_DEV, P_DEV_ACK, P_WORD, P_WORD_ACK, P_DATA, P_DATA_ACK, P_TX, P_TX_ACK
    } sea_phase_t;
    // protection change waiting for the stop
    typedef enum logic [1:0] {OP_NONE, OP_SET, OP_CLR} sea_op_t;

    // ahb-lite request from the master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } sea_ahb_req_t;
    // ahb-lite answer of this slave
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } sea_ahb_rsp_t;

    // whole control state of the slave
    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic        scl_d;
        logic        sda_d;
        sea_phase_t  phase;
        sea_phase_t  nxt;
        logic [3:0]  bitcnt;
        logic [7:0]  sh;
        logic        is_mem;
        logic [7:0]  addr;
        logic        page;
        logic [7:0]  tx;
        logic        sda_oe;
        logic        post_ack;
        logic [3:0]  ptr;
        logic [4:0]  cnt;
        sea_op_t     op;
        logic [1:0]  blk;
        logic        busy;
        logic [19:0] wcnt;
        logic [15:0] wr_done;
        logic        en;
        logic        a_valid;
        logic        a_write;
        logic [7:0]  a_addr;
        logic [31:0] hrdata;
    } sea_state_t;
endpackage

// ### verilog/sea_spd_eeprom.sv
// serial spd eeprom slave with block protection, page select and ahb-lite control
// Notes on behaviour
// [R1] write select acked, then address, then data
// [R2] write cycle only on stop after data ack
// [R3] memory ignores bus while write cycle runs
// [R4] protected byte write gets noack, unchanged
// [R5] counter advances per write unless protected
// [R6] page write takes one to sixteen bytes
// [R7] master keeps page write inside one page
// [R8] four blocks from page bit and addr7
// [R9] protection bits survive reset
// [R10] set names one block, clear frees all
// [R11] status ack when unprotected, noack when protected
// [R12] page selects half, zero after reset
// [R13] page query acks page zero, noack one
// [R14] select unacked while busy, acked after
// [R15] reads ignore protection, counter advances
// [R16] dummy write loads counter for random read
// [R17] current read outputs counter byte, increments
// [R18] sequential read continues while master acks
// [R19] master waits initialisation before commands
// [R20] array starts erased to all ones
// [R21] type 1010 memory, 0110 commands
// [R22] commands ignore the select address bits
// [R23] set/clear protection needs high-voltage select
// [R24] read noack sends slave idle
// [R25] busy flag held by write-time counter
`timescale 1ns/1ps
module sea_spd_eeprom #(
    parameter logic [19:0] WR_CNT = sea_pkg::WRITE_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    input  wire sea_pkg::sea_ahb_req_t ahb_req,
    output sea_pkg::sea_ahb_rsp_t      ahb_rsp,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    input  wire logic                  sa0_hv_in,
    input  wire logic [2:0]            lsa_in,
    output logic                       sda_out,
    output logic                       sda_oe
);
    sea_pkg::sea_state_t st;           // registered state
    sea_pkg::sea_state_t n;            // next state
    // array and protection start as delivered: erased, unprotected; no reset touches them
    logic [7:0]  mem [512] = '{default: sea_pkg::ERASED}; // R20
    logic [8:0]  pbuf_a [16];          // page latch addresses
    logic [7:0]  pbuf_d [16];          // page latch data
    logic [3:0]  prot = 4'h0;          // nonvolatile block protection
    logic        scl, sda, hv;         // synchronised pins
    logic [2:0]  logical_bus_address;                  // synchronised bus address
    logic        rise, fall;           // clock edges
    logic        start_ev, stop_ev;    // bus conditions
    logic        ack;                  // answer for the slot
    logic        buf_we;               // latch one byte
    logic        commit_mem;           // program the page latch
    logic        commit_prot;          // apply protection change
    logic [2:0]  dec;                  // blk lookup result
    sea_pkg::sea_phase_t go;           // phase after the ack slot
    logic [2:0]  sts_blk;              // block lookup of the held select byte

    // command code to block number; bit 2 flags a block command
    function automatic logic [2:0] blk_of(input logic [2:0] sel);
        case (sel)
            sea_pkg::SEL_B0: blk_of = 3'h4;
            sea_pkg::SEL_B1: blk_of = 3'h5;
            sea_pkg::SEL_B2: blk_of = 3'h6;
            sea_pkg::SEL_B3: blk_of = 3'h7;
            default:         blk_of = 3'h0;
        endcase
    endfunction

    // protocol engine, bus slave and write timer
    always_comb begin
        n           = st;
        ack         = 1'b0;
        go          = sea_pkg::P_IDLE;
        dec         = 3'h0;
        buf_we      = 1'b0;
        commit_mem  = 1'b0;
        commit_prot = 1'b0;
        // two-flop synchronisers; only stage two is read
        n.s1        = {lsa_in, sa0_hv_in, sda_in, scl_in};
        n.s2        = st.s1;
        scl         = st.s2[0];
        sda         = st.s2[1];
        hv          = st.s2[2];
        logical_bus_address         = st.s2[5:3];
        n.scl_d     = scl;
        n.sda_d     = sda;
        rise        = scl & ~st.scl_d;
        fall        = ~scl & st.scl_d;
        start_ev    = scl & st.scl_d & st.sda_d & ~sda;
        stop_ev     = scl & st.scl_d & ~st.sda_d & sda;
        // write-time countdown
        if (st.busy) begin
            n.wcnt = st.wcnt - 20'h00001;
            if (st.wcnt <= 20'h00001) begin
                n.busy = 1'b0; // R25
            end
        end
        if (start_ev) begin
            // repeated start keeps addr for random read
            n.phase    = sea_pkg::P_DEV; // R16
            n.bitcnt   = 4'h0;
            n.sda_oe   = 1'b0;
            n.post_ack = 1'b0;
            n.cnt      = 5'h00;
            n.ptr      = 4'h0;
            n.op       = sea_pkg::OP_NONE;
        end else if (stop_ev) begin
            // only the slot right after a data ack starts programming
            if (st.post_ack && st.is_mem && st.cnt != 5'h00) begin
                commit_mem = 1'b1; // R2 R6
            end
            if (st.post_ack && !st.is_mem && st.op != sea_pkg::OP_NONE) begin
                commit_prot = 1'b1; // R2 R10
            end
            if (commit_mem || commit_prot) begin
                n.busy    = 1'b1; // R25
                n.wcnt    = WR_CNT;
                n.wr_done = st.wr_done + 16'h0001;
            end
            n.phase    = sea_pkg::P_IDLE;
            n.sda_oe   = 1'b0;
            n.post_ack = 1'b0;
            n.cnt      = 5'h00;
            n.op       = sea_pkg::OP_NONE;
        end else begin
            case (st.phase)
                // receiving a byte, msb first
                sea_pkg::P_DEV, sea_pkg::P_WORD, sea_pkg::P_DATA: begin
                    if (rise && st.bitcnt < 4'h8) begin
                        n.sh     = {st.sh[6:0], sda};
                        n.bitcnt = st.bitcnt + 4'h1;
                    end else if (fall && st.bitcnt == 4'h8) begin
                        n.bitcnt = 4'h0;
                        if (st.phase == sea_pkg::P_DEV) begin
                            n.phase = sea_pkg::P_DEV_ACK;
                            dec     = blk_of(st.sh[3:1]);
                            // busy or disabled: nothing is acked
                            if (!st.en || st.busy) begin
                                ack = 1'b0; // R3 R14
                            end else if (st.sh[7:4] == sea_pkg::MEM_TYPE && st.sh[3:1] == logical_bus_address) begin
                                ack      = 1'b1; // R1 R21
                                n.is_mem = 1'b1;
                                if (st.sh[0]) begin
                                    go   = sea_pkg::P_TX; // R17
                                    n.tx = mem[{st.page, st.addr}];
                                end else begin
                                    go = sea_pkg::P_WORD;
                                end
                            end else if (st.sh[7:4] == sea_pkg::CMD_TYPE) begin
                                // select address ignored for commands
                                n.is_mem = 1'b0; // R22
                                if (st.sh[3:1] == sea_pkg::SEL_CLR && !st.sh[0]) begin
                                    ack  = hv; // R23
                                    n.op = hv ? sea_pkg::OP_CLR : sea_pkg::OP_NONE;
                                    go   = sea_pkg::P_WORD;
                                end else if (st.sh[3:1] == sea_pkg::SEL_PAGE0 && !st.sh[0]) begin
                                    ack    = 1'b1;
                                    n.page = 1'b0; // R12
                                    go     = sea_pkg::P_WORD;
                                end else if (st.sh[3:1] == sea_pkg::SEL_PAGE1 && !st.sh[0]) begin
                                    ack    = 1'b1;
                                    n.page = 1'b1; // R12
                                    go     = sea_pkg::P_WORD;
                                end else if (st.sh[3:1] == sea_pkg::SEL_PAGE0) begin
                                    ack = ~st.page; // R13
                                end else if (dec[2] && st.sh[0]) begin
                                    ack = ~prot[dec[1:0]]; // R11
                                end else if (dec[2]) begin
                                    // already protected or no high voltage: refused
                                    ack   = hv & ~prot[dec[1:0]]; // R23 R10
                                    n.op  = ack ? sea_pkg::OP_SET : sea_pkg::OP_NONE;
                                    n.blk = dec[1:0];
                                    go    = sea_pkg::P_WORD;
                                end
                            end
                            n.sda_oe = ack;
                            n.nxt    = ack ? go : sea_pkg::P_IDLE;
                        end else if (st.phase == sea_pkg::P_WORD) begin
                            // address byte always acked
                            n.phase  = sea_pkg::P_WORD_ACK;
                            n.sda_oe = 1'b1; // R1
                            n.nxt    = sea_pkg::P_DATA;
                            if (st.is_mem) begin
                                n.addr = st.sh; // R16
                            end
                        end else begin
                            n.phase = sea_pkg::P_DATA_ACK;
                            n.nxt   = sea_pkg::P_DATA;
                            if (!st.is_mem) begin
                                n.sda_oe = 1'b1;
                            end else if (prot[{st.page, st.addr[7]}]) begin
                                // protected: noack, counter holds
                                n.sda_oe = 1'b0; // R4 R5 R8
                            end else begin
                                // beyond sixteen bytes the latch wraps over
                                n.sda_oe = 1'b1; // R4 R6
                                buf_we   = 1'b1;
                                n.ptr    = st.ptr + 4'h1;
                                n.cnt    = (st.cnt == sea_pkg::PAGE_MAX) ? st.cnt : st.cnt + 5'h01;
                                n.addr   = st.addr + 8'h01; // R5
                            end
                        end
                    end else if (fall && st.phase == sea_pkg::P_DATA) begin
                        // a bit went past the ninth slot
                        n.post_ack = 1'b0; // R2
                    end
                end
                // ack slot: release at its end
                sea_pkg::P_DEV_ACK, sea_pkg::P_WORD_ACK, sea_pkg::P_DATA_ACK: begin
                    if (fall) begin
                        n.phase    = st.nxt;
                        n.bitcnt   = 4'h0;
                        n.post_ack = (st.phase == sea_pkg::P_DATA_ACK) && st.sda_oe; // R2
                        n.sda_oe   = (st.nxt == sea_pkg::P_TX) ? ~st.tx[7] : 1'b0;
                    end
                end
                // sending a byte, changes made while scl is low
                sea_pkg::P_TX: begin
                    if (rise && st.bitcnt < 4'h8) begin
                        n.bitcnt = st.bitcnt + 4'h1;
                    end else if (fall && st.bitcnt == 4'h8) begin
                        n.sda_oe = 1'b0;
                        n.phase  = sea_pkg::P_TX_ACK;
                        n.addr   = st.addr + 8'h01; // R15 R17
                    end else if (fall) begin
                        n.sda_oe = ~st.tx[3'h7 - st.bitcnt[2:0]];
                    end
                end
                // master answers the byte
                sea_pkg::P_TX_ACK: begin
                    if (rise && sda) begin
                        n.phase = sea_pkg::P_IDLE; // R24
                    end else if (fall) begin
                        // next byte regardless of protection
                        n.tx     = mem[{st.page, st.addr}]; // R18 R15
                        n.sda_oe = ~mem[{st.page, st.addr}][7];
                        n.bitcnt = 4'h0;
                        n.phase  = sea_pkg::P_TX;
                    end
                end
                default: begin
                    n.sda_oe = 1'b0;
                end
            endcase
        end
        // ahb data phase write
        if (st.a_valid && st.a_write && st.a_addr == sea_pkg::CTRL_OFS) begin
            n.en = ahb_req.hwdata[0];
        end
        // ahb address phase; read data prepared for the data phase
        n.a_valid = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        n.a_write = ahb_req.hwrite;
        n.a_addr  = ahb_req.haddr[7:0];
        if (n.a_valid && !ahb_req.hwrite) begin
            case (ahb_req.haddr[7:0])
                sea_pkg::CTRL_OFS:  n.hrdata = {31'h00000000, st.en};
                sea_pkg::STAT_OFS:  n.hrdata = {26'h0000000, prot, st.page, st.busy};
                sea_pkg::COUNT_OFS: n.hrdata = {16'h0000, st.wr_done};
                default:            n.hrdata = 32'h00000000;
            endcase
        end
    end

    // state register; nonvolatile parts live elsewhere
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0; // R12
            st.phase  <= sea_pkg::P_IDLE;
            st.nxt    <= sea_pkg::P_IDLE;
            st.op     <= sea_pkg::OP_NONE;
            st.en     <= sea_pkg::CTRL_RST;
            st.scl_d  <= 1'b1;
            st.sda_d  <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // page latch, array programming and protection bits; reset leaves them
    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            pbuf_a[st.ptr] <= {st.page, st.addr};
            pbuf_d[st.ptr] <= st.sh;
        end
        if (commit_mem) begin
            for (int i = 0; i < sea_pkg::PAGE_BYTES; i++) begin
                if (5'(i) < st.cnt) begin
                    mem[pbuf_a[i]] <= pbuf_d[i]; // R6
                end
            end
        end
        if (commit_prot) begin
            prot <= (st.op == sea_pkg::OP_CLR) ? 4'h0 : (prot | (4'h1 << st.blk)); // R9 R10
        end
    end

    // open-drain data: drive low only
    assign sda_out           = 1'b0;
    assign sda_oe            = st.sda_oe;
    assign ahb_rsp.hrdata    = st.hrdata;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;
    assign sts_blk           = blk_of(st.sh[3:1]);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // no ack while the write cycle runs
    property p_busy_noack;
        st.busy && st.phase == sea_pkg::P_DEV_ACK |-> !st.sda_oe;
    endproperty
    a_busy_noack: assert property (p_busy_noack) else $error("ack given while busy"); // R3 R14
    // programming only follows a data ack
    property p_trigger;
        $rose(st.busy) |-> $past(st.post_ack) && $past(stop_ev);
    endproperty
    a_trigger: assert property (p_trigger) else $error("write cycle without stop after data ack"); // R2
    // busy starts at the full count
    property p_wtime;
        $rose(st.busy) |-> st.wcnt == WR_CNT ##1 st.busy;
    endproperty
    a_wtime: assert property (p_wtime) else $error("write timer not loaded"); // R25
    // protected data byte: noack and counter held
    property p_prot_wr;
        st.phase == sea_pkg::P_DATA && fall && st.bitcnt == 4'h8 && st.is_mem
            && prot[{st.page, st.addr[7]}] && !start_ev && !stop_ev
            |=> !st.sda_oe && st.addr == $past(st.addr);
    endproperty
    a_prot_wr: assert property (p_prot_wr) else $error("protected write accepted"); // R4 R5
    // page query answer
    property p_page_query;
        $changed(st.phase) && st.phase == sea_pkg::P_DEV_ACK
            && st.sh == {sea_pkg::CMD_TYPE, sea_pkg::SEL_PAGE0, 1'b1}
            |-> st.sda_oe == (!st.page && !$past(st.busy) && $past(st.en));
    endproperty
    a_page_query: assert property (p_page_query) else $error("page query answer wrong"); // R13
    // master noack ends the read
    property p_read_nack;
        st.phase == sea_pkg::P_TX_ACK && rise && sda && !stop_ev && !start_ev
            |=> st.phase == sea_pkg::P_IDLE ##1 !st.sda_oe;
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("slave kept sending after noack"); // R24
    // counter steps after each byte sent
    property p_read_inc;
        st.phase == sea_pkg::P_TX && fall && st.bitcnt == 4'h8 && !stop_ev && !start_ev
            |=> st.addr == $past(st.addr) + 8'h01;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read counter did not advance"); // R15 R17
    // clear frees all four blocks
    property p_clear_all;
        commit_prot && st.op == sea_pkg::OP_CLR |=> prot == 4'h0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear left a block protected"); // R10
    // page latch never holds more than sixteen
    property p_page_len;
        st.cnt <= sea_pkg::PAGE_MAX;
    endproperty
    a_page_len: assert property (p_page_len) else $error("page count over sixteen"); // R6
    // status answer follows the block bit
    property p_status;
        $changed(st.phase) && st.phase == sea_pkg::P_DEV_ACK && st.sh[7:4] == sea_pkg::CMD_TYPE && st.sh[0]
            && sts_blk[2] && $past(st.en) && !$past(st.busy)
            |-> st.sda_oe == !prot[sts_blk[1:0]];
    endproperty
    a_status: assert property (p_status) else $error("status answer wrong"); // R11

    c_write_cycle: cover property (commit_mem ##1 $rose(st.busy));
    c_prot_set: cover property (commit_prot && st.op == sea_pkg::OP_SET);
    c_seq_read: cover property (st.phase == sea_pkg::P_TX_ACK && fall ##1 st.phase == sea_pkg::P_TX);
    c_poll_nack: cover property (st.busy && st.phase == sea_pkg::P_DEV_ACK);
endmodule

// ### dv/sea_host.sv
// serial bus master model facing the eeprom slave
`timescale 1ns/1ps
module sea_host (
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic mst_oe;  // master pulls data low
    // open drain with pull-up: a released wire reads high
    assign sda = !(sda_oe | mst_oe);
    // clock stands high outside frames
    initial begin
        scl    = 1'b1;
        mst_oe = 1'b0;
    end
    // one 80 ns slot, data changed only while clock low
    task automatic slot(input logic b, output logic r);
        mst_oe = !b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        #20;
    endtask
    // start or repeated start
    task automatic start();
        mst_oe = 1'b0;
        #20 scl = 1'b1;
        #40 mst_oe = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask
    // stop, then bus idle
    task automatic stop();
        mst_oe = 1'b1;
        #20 scl = 1'b1;
        #40 mst_oe = 1'b0;
        #40;
    endtask
    // byte msb first, then ack slot; mack drives ack on reads
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            slot(tx[i], r);
            rx[i] = r;
        end
        slot(!mack, r);
        ak = !r;
    endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
module testbench;
    logic                  core_clk;
    logic                  arst_n;
    sea_pkg::sea_ahb_req_t mreq;     // master side request
    sea_pkg::sea_ahb_req_t ahb_req;  // with hready looped back
    sea_pkg::sea_ahb_rsp_t ahb_rsp;
    logic                  scl;
    logic                  sda;
    logic                  sda_oe;
    logic                  hv;
    logic [2:0]            logical_bus_address;
    logic [31:0]           exp_q[$];
    logic [31:0]           act_q[$];
    int                    fail_count;
    int                    checks;
    int                    cyc;
    logic [7:0]            rx, ms, mr, ra, rd;
    logic                  ak;
    // the single slave's hreadyout drives the bus hready
    always_comb begin
        ahb_req        = mreq;
        ahb_req.hready = ahb_rsp.hreadyout;
    end
    // short write time keeps polling visible yet brief
    sea_spd_eeprom #(.WR_CNT(20'h000C8)) dut (.core_clk(core_clk), .arst_n(arst_n), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .scl_in(scl), .sda_in(sda), .sa0_hv_in(hv), .lsa_in(logical_bus_address), .sda_out(), .sda_oe(sda_oe));
    sea_host host (.sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic cmp(input logic [31:0] e, input logic [31:0] a);
        checks++;
        if (a !== e) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    // watcher pairs each result with the oldest expectation
    always @(posedge core_clk) begin
        if (act_q.size() != 0) cmp(exp_q.pop_front(), act_q.pop_front());
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic note(input logic [31:0] e, input logic [31:0] a);
        exp_q.push_back(e);
        act_q.push_back(a);
    endtask
    // ahb single word: hold address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        mreq <= '{1'b1, {24'h0, a}, 2'b10, w, 3'h2, 32'h0, 1'b1};
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        mreq <= '{1'b0, {24'h0, a}, 2'b00, w, 3'h2, d, 1'b1};
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        if (!w) note(d, ahb_rsp.hrdata);
    endtask
    task automatic wb(input logic [7:0] b, input logic e);
        host.xfer(b, 1'b0, rx, ak);
        note({31'h0, e}, {31'h0, ak});
    endtask
    task automatic rdb(input logic [7:0] e, input logic mack);
        host.xfer(8'hFF, mack, rx, ak);
        note({24'h0, e}, {24'h0, rx});
    endtask
    function automatic logic [7:0] cb(input logic [2:0] c, input logic r);
        return {sea_pkg::CMD_TYPE, c, r};
    endfunction
    // first poll refused, then repeat until acked
    task automatic wait_wr();
        host.start();
        wb(ms, 1'b0);
        for (int i = 0; i < 8 && !ak; i++) begin
            host.stop();
            host.start();
            host.xfer(ms, 1'b0, rx, ak);
        end
        note(32'h1, {31'h0, ak});
        host.stop();
    endtask
    // random read: dummy write, restart, read select
    task automatic rr(input logic [7:0] a, input logic [7:0] e);
        host.start();
        wb(ms, 1'b1);
        wb(a, 1'b1);
        host.start();
        wb(mr, 1'b1);
        rdb(e, 1'b0);
        host.stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        host.start();
        wb(ms, 1'b1);
        wb(a, 1'b1);
        wb(d, e);
        host.stop();
    endtask
    task automatic cmd(input logic [7:0] s, input logic e, input logic body);
        host.start();
        wb(s, e);
        if (body) wb(8'h00, 1'b1);
        if (body) wb(8'h00, 1'b1);
        host.stop();
        if (body) wait_wr();
    endtask
    task automatic final_report();
        $display("fail_count=%0d checks=%0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h7fae4bec));
        {fail_count, checks, cyc} = '0;
        {arst_n, hv, mreq} = '0;
        logical_bus_address = 3'($urandom);
        ra = {1'b0, 3'($urandom), 4'h4};  // two bytes stay in one page
        rd = 8'($urandom);
        ms = {sea_pkg::MEM_TYPE, logical_bus_address, 1'b0};
        mr = ms | 8'h01;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        ahb(1'b0, 8'h04, 32'h0);
        ahb(1'b0, 8'h0C, 32'h0);
        rr(ra, 8'hFF);
        wr(ra, rd, 1'b1);
        wait_wr();
        wr(ra, rd, 1'b1);
        host.start();
        wb(ms, 1'b0);
        host.stop();
        wait_wr();
        host.start();
        wb(ms, 1'b1);
        wb(ra, 1'b1);
        wb(rd, 1'b1);
        wb(~rd, 1'b1);
        host.stop();
        wait_wr();
        ahb(1'b0, 8'h08, 32'h3);
        rr(ra, rd);
        host.start();
        wb(mr, 1'b1);
        rdb(~rd, 1'b1);
        rdb(8'hFF, 1'b0);
        host.stop();
        host.start();
        wb(ms, 1'b1);
        wb(ra, 1'b1);
        host.stop();
        ahb(1'b0, 8'h08, 32'h3);
        cmd(cb(sea_pkg::SEL_B0, 1'b0), 1'b0, 1'b0);
        @(posedge core_clk) hv <= 1'b1;
        cmd(cb(sea_pkg::SEL_B0, 1'b0), 1'b1, 1'b1);
        cmd(cb(sea_pkg::SEL_B0, 1'b1), 1'b0, 1'b0);
        cmd(cb(sea_pkg::SEL_B1, 1'b1), 1'b1, 1'b0);
        wr(ra, ~rd, 1'b0);
        host.start();
        wb(mr, 1'b1);
        rdb(rd, 1'b0);
        host.stop();
        @(posedge core_clk) arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        ahb(1'b0, 8'h04, 32'h4);
        cmd(cb(sea_pkg::SEL_CLR, 1'b0), 1'b1, 1'b1);
        cmd(cb(sea_pkg::SEL_B0, 1'b1), 1'b1, 1'b0);
        cmd(cb(sea_pkg::SEL_PAGE1, 1'b0), 1'b1, 1'b0);
        cmd(cb(sea_pkg::SEL_PAGE0, 1'b1), 1'b0, 1'b0);
        rr(ra, 8'hFF);
        cmd(cb(sea_pkg::SEL_PAGE0, 1'b0), 1'b1, 1'b0);
        rr(ra, rd);
        cmd(cb(sea_pkg::SEL_PAGE1, 1'b0), 1'b1, 1'b0);
        ahb(1'b1, 8'h00, 32'h0);
        cmd(ms, 1'b0, 1'b0);
        ahb(1'b1, 8'h00, 32'h1);
        @(posedge core_clk) arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmd(cb(sea_pkg::SEL_PAGE0, 1'b1), 1'b1, 1'b0);
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule
